// ---- rtl/hcmc_top.sv ----
`default_nettype none
module hcmc_top (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        BIT_TICK,
	input  wire logic        SLOT_ACTIVE,
	output logic             TXD,
	output logic             TXD_OE,
	output logic             RX_ENABLED
);
	typedef struct packed
	{
		logic [15:0]                       mode;
		logic [31:0]                       zds;
		logic [31:0]                       ris;
		logic                              wr_ph;
		logic                              rd_ph;
		logic                              rd_done;
		logic [hcmc_pkg::ADDR_W-1:0]       addr;
		logic [31:0]                       rdata;
		hcmc_pkg::hcmc_tx_state_type       state;
		logic [hcmc_pkg::FCNT_W-1:0]       flag_cnt;
		logic [1:0]                        idle_cnt;
		logic                              first;
	} hcmc_top_state_type;

	localparam hcmc_top_state_type S_RESET = '{
		mode:     hcmc_pkg::MODE_RESET,
		zds:      32'h0000_0000,
		ris:      32'h0000_0000,
		wr_ph:    1'h0,
		rd_ph:    1'h0,
		rd_done:  1'h0,
		addr:     8'h00,
		rdata:    32'h0000_0000,
		state:    hcmc_pkg::ST_OFF,
		flag_cnt: 4'h0,
		idle_cnt: 2'h0,
		first:    1'h1
	};

	hcmc_top_state_type  s_q;
	hcmc_top_state_type  s_d;
	logic                tx_en;
	logic                hdlc;
	logic                idle_en;
	logic [3:0]          flags_min;
	logic                data_hit;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [8:0]          fifo_out_data;
	logic                fifo_last;
	logic                fifo_pop;
	logic                ser_take;
	logic [7:0]          tx_byte;
	logic                idle_done;
	logic                rx_en;

	// ****************************************
	// Register read decode
	// ****************************************
	function automatic logic [31:0] read_reg(
		input logic [7:0]  addr,
		input logic [15:0] mode,
		input logic [31:0] zds,
		input logic [31:0] ris,
		input logic [6:0]  stat
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (addr)
			hcmc_pkg::OFS_MODE:   v = {16'h0000, mode};
			hcmc_pkg::OFS_STATUS: v = {25'h000_0000, stat};
			hcmc_pkg::OFS_ZDS:    v = zds;
			hcmc_pkg::OFS_RIS:    v = ris;
			default:              v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign tx_en     = s_q.mode[hcmc_pkg::BIT_TX_EN];
	assign hdlc      = s_q.mode[hcmc_pkg::BIT_HDLC];
	assign idle_en   = s_q.mode[hcmc_pkg::BIT_IDLE];
	assign flags_min = s_q.mode[hcmc_pkg::FCNT_LSB +: hcmc_pkg::FCNT_W];
	assign fifo_last = fifo_out_data[hcmc_pkg::DATA_LAST_BIT];
	assign data_hit  = s_q.wr_ph && (s_q.addr == hcmc_pkg::OFS_TXDATA);

	// ****************************************
	// Bus answers
	// ****************************************
	assign HREADYOUT = s_q.rd_ph ? s_q.rd_done : !(data_hit && !fifo_in_ready);
	assign HRESP     = hcmc_pkg::RESP_OKAY;
	assign HRDATA    = s_q.rdata;
	assign TXD_OE    = SLOT_ACTIVE;
	assign RX_ENABLED = rx_en;

	// Receiver counts as enabled once ZDS holds the start value for the protocol and RIS is nonzero
	assign rx_en = (hdlc ? (s_q.zds == hcmc_pkg::ZDS_INIT_HDLC)
		: (s_q.zds == hcmc_pkg::ZDS_INIT_TRANS)) && (s_q.ris != 32'h0000_0000);

	assign idle_done = (s_q.idle_cnt + 2'h1) >=
		(s_q.first ? hcmc_pkg::IDLE_MIN_START : hcmc_pkg::IDLE_MIN_GAP);

	hcmc_fifo #(
		.WIDTH (hcmc_pkg::FIFO_W),
		.DEPTH (hcmc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.in_valid  (data_hit),
		.in_data   (HWDATA[hcmc_pkg::FIFO_W-1:0]),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_pop)
	);

	hcmc_serializer u_ser (
		.clk        (MCLK),
		.rst_n      (RESET_N),
		.bit_tick   (BIT_TICK && SLOT_ACTIVE),
		.force_ones (!tx_en),
		.byte_in    (tx_byte),
		.take       (ser_take),
		.txd        (TXD)
	);

	always_comb
	begin
		s_d      = s_q;
		tx_byte  = hcmc_pkg::ONES_OCTET;
		fifo_pop = 1'h0;

		// ****************************************
		// Bus slave
		// ****************************************
		if (s_q.wr_ph && HREADY)
		begin
			unique case (s_q.addr)
				hcmc_pkg::OFS_MODE: s_d.mode = HWDATA[15:0] & hcmc_pkg::MODE_WMASK;
				hcmc_pkg::OFS_ZDS:  s_d.zds = HWDATA;
				hcmc_pkg::OFS_RIS:  s_d.ris = HWDATA;
				default:            s_d.mode = s_q.mode;
			endcase
		end
		if (s_q.rd_ph && !s_q.rd_done)
		begin
			s_d.rdata   = read_reg(s_q.addr, s_q.mode, s_q.zds, s_q.ris,
				{rx_en, fifo_in_ready, fifo_out_valid, s_q.state});
			s_d.rd_done = 1'h1;
		end
		if (HREADY)
		begin
			s_d.wr_ph   = HSEL && HTRANS[hcmc_pkg::TRANS_ACT_BIT] && HWRITE
				&& (HSIZE == hcmc_pkg::SIZE_WORD);
			s_d.rd_ph   = HSEL && HTRANS[hcmc_pkg::TRANS_ACT_BIT] && !HWRITE;
			s_d.addr    = HADDR[hcmc_pkg::ADDR_W-1:0];
			s_d.rd_done = 1'h0;
		end

		// ****************************************
		// Transmit framing
		// ****************************************
		if (!tx_en)
		begin
			s_d.state    = hcmc_pkg::ST_OFF;
			s_d.flag_cnt = 4'h0;
			s_d.idle_cnt = 2'h0;
			s_d.first    = 1'h1;
		end
		else if (ser_take)
		begin
			unique case (s_q.state)
				hcmc_pkg::ST_OFF:
				begin
					tx_byte = hcmc_pkg::ONES_OCTET;
					if (!hdlc)
						s_d.state = hcmc_pkg::ST_DATA;
					else if (idle_en)
					begin
						s_d.state    = hcmc_pkg::ST_IDLE;
						s_d.idle_cnt = 2'h0;
					end
					else
					begin
						s_d.state    = hcmc_pkg::ST_FLAG;
						s_d.flag_cnt = 4'h0;
					end
				end
				hcmc_pkg::ST_IDLE:
				begin
					tx_byte = hcmc_pkg::IDLE_OCTET;
					if (!hdlc)
						s_d.state = hcmc_pkg::ST_DATA;
					else if (idle_done && fifo_out_valid)
					begin
						s_d.state    = hcmc_pkg::ST_FLAG;
						s_d.flag_cnt = 4'h0;
						s_d.first    = 1'h0;
					end
					else if (s_q.idle_cnt != 2'h3)
						s_d.idle_cnt = s_q.idle_cnt + 2'h1;
				end
				hcmc_pkg::ST_FLAG:
				begin
					tx_byte = hcmc_pkg::FLAG_OCTET;
					if (!hdlc)
						s_d.state = hcmc_pkg::ST_DATA;
					else if ((s_q.flag_cnt >= flags_min) && fifo_out_valid)
						s_d.state = hcmc_pkg::ST_DATA;
					else if (s_q.flag_cnt < flags_min)
						s_d.flag_cnt = s_q.flag_cnt + 4'h1;
				end
				hcmc_pkg::ST_DATA:
				begin
					if (fifo_out_valid)
					begin
						tx_byte  = fifo_out_data[7:0];
						fifo_pop = 1'h1;
						if (hdlc && fifo_last)
						begin
							s_d.state    = idle_en ? hcmc_pkg::ST_IDLE
								: hcmc_pkg::ST_FLAG;
							s_d.idle_cnt = 2'h0;
							s_d.flag_cnt = 4'h0;
						end
					end
					else if (hdlc)
					begin
						tx_byte      = hcmc_pkg::FLAG_OCTET;
						s_d.state    = hcmc_pkg::ST_FLAG;
						s_d.flag_cnt = 4'h0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			s_q <= S_RESET;
		else
			s_q <= s_d;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	sequence frame_end_s;
		ser_take && tx_en && hdlc && (s_q.state == hcmc_pkg::ST_DATA)
			&& fifo_out_valid && fifo_last;
	endsequence

	sequence flag_take_s;
		ser_take && tx_en && hdlc && (s_q.state == hcmc_pkg::ST_FLAG);
	endsequence

	sequence idle_take_s;
		ser_take && tx_en && hdlc && (s_q.state == hcmc_pkg::ST_IDLE);
	endsequence

	mode_write_only_a: assert property (
		!$stable(s_q.mode) |-> $past(s_q.wr_ph && HREADY && s_q.addr == hcmc_pkg::OFS_MODE))
		else $error("mode word changed without a bus write");

	transparent_data_a: assert property (
		ser_take && tx_en && !hdlc |=> s_q.state == hcmc_pkg::ST_DATA)
		else $error("transparent channel left the data state");

	flags_before_data_a: assert property (
		flag_take_s ##1 s_q.state == hcmc_pkg::ST_DATA
			|-> $past(s_q.flag_cnt) >= $past(flags_min))
		else $error("data started before flag count plus one flags");

	flag_fill_a: assert property (
		flag_take_s and !fifo_out_valid |=> s_q.state == hcmc_pkg::ST_FLAG)
		else $error("flags not kept while no frame ready");

	flag_share_a: assert property (
		frame_end_s and !idle_en |=> s_q.state == hcmc_pkg::ST_FLAG && s_q.flag_cnt == 4'h0)
		else $error("frame end not followed by flag");

	idle_gap_a: assert property (
		frame_end_s and idle_en |=> s_q.state == hcmc_pkg::ST_IDLE)
		else $error("no idle octet after frame");

	idle_octet_a: assert property (
		ser_take && tx_en && s_q.state == hcmc_pkg::ST_IDLE |-> tx_byte == hcmc_pkg::IDLE_OCTET)
		else $error("idle state sent a non idle octet");

	start_idles_a: assert property (
		ser_take && tx_en && s_q.state == hcmc_pkg::ST_IDLE && s_q.first
			&& s_q.idle_cnt == 2'h0 |=> s_q.state != hcmc_pkg::ST_FLAG)
		else $error("fewer than two idles after start");

	disabled_ones_a: assert property (
		!tx_en ##1 !tx_en |-> TXD == 1'h1)
		else $error("disabled transmitter drove a zero");

	flag_octet_a: assert property (
		flag_take_s |-> tx_byte == hcmc_pkg::FLAG_OCTET)
		else $error("flag state sent a non flag octet");

	rx_enable_a: assert property (
		RX_ENABLED |-> s_q.ris != 32'h0000_0000 && (s_q.zds == hcmc_pkg::ZDS_INIT_HDLC
			|| s_q.zds == hcmc_pkg::ZDS_INIT_TRANS))
		else $error("receiver enabled without start values");

	idle_to_flags_a: assert property (
		idle_take_s and (idle_done && fifo_out_valid)
			|=> s_q.state == hcmc_pkg::ST_FLAG && s_q.flag_cnt == 4'h0)
		else $error("ready frame did not start with flags");

	idle_hold_a: assert property (
		idle_take_s and !fifo_out_valid |=> s_q.state == hcmc_pkg::ST_IDLE)
		else $error("idle octets stopped while no frame ready");

	data_octet_a: assert property (
		ser_take && tx_en && s_q.state == hcmc_pkg::ST_DATA && fifo_out_valid
			|-> fifo_pop && tx_byte == fifo_out_data[7:0])
		else $error("data state did not send the queued octet");

	first_flag_a: assert property (
		ser_take && tx_en && hdlc && !idle_en && s_q.state == hcmc_pkg::ST_OFF
			|=> s_q.state == hcmc_pkg::ST_FLAG)
		else $error("first frame not preceded by a flag");

	disabled_state_a: assert property (
		!tx_en |=> s_q.state == hcmc_pkg::ST_OFF)
		else $error("disabled transmitter left the off state");

	read_wait_a: assert property (
		s_q.rd_ph && !s_q.rd_done |-> !HREADYOUT ##1 HREADYOUT)
		else $error("read answer not after one wait state");
endmodule
`default_nettype wire

// ---- shared/hcmc_pkg.sv ----
// Notes on behaviour
// - Mode control word is sixteen bits, zero at reset, programmed before use.
// - Protocol bit picks transparent at zero and HDLC framing at one.
// - Without idle insertion, send flag count plus one flags, then data.
// - Without idle insertion, keep sending flags while no frame is ready.
// - Without idle insertion and zero count, one flag separates frames.
// - Extra flags may appear under load; receivers tolerate them.
// - With idle insertion, at least one idle octet lies between frames.
// - With idle insertion, idle octets continue while no frame is ready.
// - With idle insertion, ready data gets flag count plus one flags first; code stays idle until disabled if no frame is ready by the third idle octet.
// - Fresh transmitter sends ones: init octet, two idles, flags, data; code sends the idles only with idle insertion, flags only in HDLC.
// - Transmit disabled drives all ones in the assigned time slot.
// - Transmit enabled sends data per protocol and other settings.
// - No receive enable bit; writing initial state words enables receiving.
// - Flag count sits in the low nibble; one flag always precedes frames.
`default_nettype none
package hcmc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  OFS_MODE        = 8'h00;
	localparam logic [7:0]  OFS_TXDATA      = 8'h04;
	localparam logic [7:0]  OFS_STATUS      = 8'h08;
	localparam logic [7:0]  OFS_ZDS         = 8'h0C;
	localparam logic [7:0]  OFS_RIS         = 8'h10;
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [15:0] MODE_WMASK      = 16'hB18F;
	localparam int unsigned BIT_HDLC        = 15;
	localparam int unsigned BIT_IDLE        = 13;
	localparam int unsigned BIT_TX_EN       = 12;
	localparam int unsigned FCNT_LSB        = 0;
	localparam int unsigned FCNT_W          = 4;
	localparam logic [31:0] ZDS_INIT_HDLC   = 32'h0000_0080;
	localparam logic [31:0] ZDS_INIT_TRANS  = 32'h1800_0080;
	localparam int unsigned DATA_LAST_BIT   = 8;
	// ****************************************
	// Bus and line constants
	// ****************************************
	localparam int unsigned TRANS_ACT_BIT   = 1;
	localparam logic [2:0]  SIZE_WORD       = 3'h2;
	localparam logic        RESP_OKAY       = 1'h0;
	localparam int unsigned FIFO_W          = 9;
	localparam int unsigned FIFO_DEPTH      = 8;
	localparam int unsigned OCTET_BITS      = 8;
	localparam logic [2:0]  BIT_CNT_LAST    = 3'h7;
	localparam logic [7:0]  FLAG_OCTET      = 8'h7E;
	localparam logic [7:0]  IDLE_OCTET      = 8'hFF;
	localparam logic [7:0]  ONES_OCTET      = 8'hFF;
	localparam logic [1:0]  IDLE_MIN_START  = 2'h2;
	localparam logic [1:0]  IDLE_MIN_GAP    = 2'h1;
	typedef enum logic [3:0]
	{
		ST_OFF  = 4'h1,
		ST_IDLE = 4'h2,
		ST_FLAG = 4'h4,
		ST_DATA = 4'h8
	} hcmc_tx_state_type;
endpackage
`default_nettype wire

// ---- rtl/hcmc_fifo.sv ----
`default_nettype none
module hcmc_fifo #(
	parameter int unsigned WIDTH = hcmc_pkg::FIFO_W,
	parameter int unsigned DEPTH = hcmc_pkg::FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} hcmc_fifo_state_type;
	hcmc_fifo_state_type s_q;
	hcmc_fifo_state_type s_d;
	logic                push;
	logic                pop;

	assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
	assign out_valid = s_q.cnt != '0;
	assign out_data  = s_q.mem[s_q.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
		end
		if (pop)
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule
`default_nettype wire

// ---- rtl/hcmc_serializer.sv ----
`default_nettype none
module hcmc_serializer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       bit_tick,
	input  wire logic       force_ones,
	input  wire logic [7:0] byte_in,
	output logic            take,
	output logic            txd
);
	typedef struct packed
	{
		logic [6:0] sh;
		logic [2:0] cnt;
		logic       txd;
	} hcmc_ser_state_type;
	localparam hcmc_ser_state_type S_RESET = '{sh: 7'h7F, cnt: 3'h0, txd: 1'h1};
	hcmc_ser_state_type s_q;
	hcmc_ser_state_type s_d;

	assign take = bit_tick && (s_q.cnt == 3'h0);
	assign txd  = s_q.txd;

	// ****************************************
	// Octet shifter, first bit out on the load tick
	// ****************************************
	always_comb
	begin
		s_d = s_q;
		if (take)
		begin
			s_d.txd = byte_in[0];
			s_d.sh  = byte_in[7:1];
			s_d.cnt = hcmc_pkg::BIT_CNT_LAST;
		end
		else if (bit_tick)
		begin
			s_d.txd = s_q.sh[0];
			s_d.sh  = {1'h1, s_q.sh[6:1]};
			s_d.cnt = s_q.cnt - 3'h1;
		end
		if (force_ones)
			s_d.txd = 1'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= S_RESET;
		else
			s_q <= s_d;
	end
endmodule
`default_nettype wire

// ---- testbench/hcmc_line_model.sv ----
`default_nettype none
module hcmc_line_model #(
	parameter int TICK_DIV = 4
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic txd,
	input  wire logic txd_oe,
	output logic      bit_tick,
	output logic      slot_active
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Slot timing and line capture
	// ****************************************
	int   cnt;
	int   slot;
	logic bits[$];
	// One slot in four belongs to another channel, which stalls this one
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			slot <= 0;
			bit_tick <= 1'b0;
			slot_active <= 1'b0;
		end
		else
		begin
			cnt <= (cnt + 1) % TICK_DIV;
			bit_tick <= (cnt == TICK_DIV - 2);
			if (bit_tick)
			begin
				slot <= (slot + 1) % 4;
				slot_active <= (slot != 2);
				if (slot_active && txd_oe)
					bits.push_back(txd);
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/hdlc_channel_mode_control_tb.sv ----
`default_nettype none
module hdlc_channel_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        reset_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        bit_tick;
	logic        slot_active;
	logic        txd;
	logic        txd_oe;
	logic        rx_enabled;
	logic [31:0] rd;
	int          fails = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	hcmc_top hcmc_top_inst (
		.MCLK(mclk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .BIT_TICK(bit_tick),
		.SLOT_ACTIVE(slot_active), .TXD(txd), .TXD_OE(txd_oe), .RX_ENABLED(rx_enabled)
	);

	hcmc_line_model hcmc_line_model_inst (
		.clk(mclk), .rst_n(reset_n), .txd(txd), .txd_oe(txd_oe),
		.bit_tick(bit_tick), .slot_active(slot_active)
	);

	// ****************************************
	// Clock, timeout and report
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end

	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ****************************************
	// Bus master and frame scenario
	// ****************************************
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic frame_run(input logic [15:0] mode, input int mf, input int n,
		input logic [7:0] tail, input logic [3:0] st);
		logic [7:0] d[$];
		logic [7:0] oq[$];
		logic [7:0] o;
		int         i;
		int         k;
		int         nf;
		ahb(1'b1, hcmc_pkg::OFS_MODE, 32'h0, rd);
		for (k = 0; k < n; k++)
		begin
			d.push_back(8'(($urandom % 62) * 2));
			ahb(1'b1, hcmc_pkg::OFS_TXDATA, {23'h0, k == n - 1, d[k]}, rd);
		end
		ahb(1'b0, hcmc_pkg::OFS_STATUS, 32'h0, rd);
		chk("fifo_held", (n == 8) ? 32'h1 : 32'h3, {30'h0, rd[5:4]});
		hcmc_line_model_inst.bits.delete();
		repeat (300) @(posedge mclk);
		nf = 0;
		foreach (hcmc_line_model_inst.bits[k])
			if (hcmc_line_model_inst.bits[k] !== 1'b1)
				nf++;
		chk("ones_off", 32'h0, nf);
		ahb(1'b1, hcmc_pkg::OFS_MODE, {16'h0, mode}, rd);
		repeat (1200) @(posedge mclk);
		i = 0;
		while (i < hcmc_line_model_inst.bits.size() && hcmc_line_model_inst.bits[i] === 1'b1)
			i++;
		while (i + 8 <= hcmc_line_model_inst.bits.size())
		begin
			for (k = 0; k < 8; k++)
				o[k] = hcmc_line_model_inst.bits[i + k];
			oq.push_back(o);
			i += 8;
		end
		nf = 0;
		while (nf < oq.size() && oq[nf] === hcmc_pkg::FLAG_OCTET)
			nf++;
		chk("flags", 32'h1, mode[15] ? 32'(nf >= mf) : 32'(nf == 0));
		for (k = 0; k <= n; k++)
			chk("octet", (k < n) ? d[k] : tail, oq[nf + k]);
		ahb(1'b0, hcmc_pkg::OFS_STATUS, 32'h0, rd);
		if (st != 4'h0)
			chk("tx_state", {28'h0, st}, {28'h0, rd[3:0]});
		chk("fifo_empty", 32'h2, {30'h0, rd[5:4]});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = hcmc_pkg::SIZE_WORD;
		hwdata = 32'h0;
		void'($urandom(91));
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk("txd_reset", 32'h1, {31'h0, txd});
		chk("resp", 32'h0, {31'h0, hresp});
		chk("txd_oe", {31'h0, slot_active}, {31'h0, txd_oe});
		ahb(1'b0, hcmc_pkg::OFS_MODE, 32'h0, rd);
		chk("mode_reset", 32'h0, rd);
		ahb(1'b1, hcmc_pkg::OFS_MODE, 32'hFFFF_B18F, rd);
		hsize <= 3'h1;
		ahb(1'b1, hcmc_pkg::OFS_MODE, 32'h0, rd);
		hsize <= hcmc_pkg::SIZE_WORD;
		ahb(1'b0, hcmc_pkg::OFS_MODE, 32'h0, rd);
		chk("mode_mask", {16'h0, hcmc_pkg::MODE_WMASK}, rd);
		ahb(1'b0, 8'h20, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		ahb(1'b1, hcmc_pkg::OFS_MODE, 32'h8000, rd);
		ahb(1'b1, hcmc_pkg::OFS_ZDS, hcmc_pkg::ZDS_INIT_HDLC, rd);
		@(posedge mclk);
		chk("rx_part", 32'h0, {31'h0, rx_enabled});
		ahb(1'b1, hcmc_pkg::OFS_RIS, 32'h1, rd);
		@(posedge mclk);
		chk("rx_hdlc", 32'h1, {31'h0, rx_enabled});
		ahb(1'b1, hcmc_pkg::OFS_MODE, 32'h0, rd);
		@(posedge mclk);
		chk("rx_proto", 32'h0, {31'h0, rx_enabled});
		ahb(1'b1, hcmc_pkg::OFS_ZDS, hcmc_pkg::ZDS_INIT_TRANS, rd);
		@(posedge mclk);
		chk("rx_trans", 32'h1, {31'h0, rx_enabled});
		frame_run(16'hB001, 2, 8, hcmc_pkg::IDLE_OCTET, 4'h2);
		frame_run(16'h9000, 1, 5, hcmc_pkg::FLAG_OCTET, 4'h4);
		frame_run(16'h9003, 4, 3, hcmc_pkg::FLAG_OCTET, 4'h4);
		frame_run(16'h1000, 0, 4, hcmc_pkg::ONES_OCTET, 4'h8);
		results();
	end
endmodule
`default_nettype wire
